/* design/arcm_clk_gen.sv */
// master mode bit clock and frame sync generator
`timescale 1ns/1ps
module arcm_clk_gen #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned BIT_W = 12
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // setup
    input wire logic en_i,
    input wire logic [CNT_W-1:0] half_i,
    input wire logic [BIT_W-1:0] bits_i,
    // generated clocks
    output logic bit_clk_o,
    output logic frame_sync_o
);
    logic [CNT_W-1:0] cnt;
    logic [BIT_W-1:0] bit_idx;

    if (CNT_W < 2 || BIT_W < 5) begin : g_bad_w
        $error("counter widths too small");
    end

    // half period enable pulse
    wire logic tick = cnt >= half_i - 1'b1;
    wire logic last = bit_idx >= bits_i - 1'b1;
    wire logic [BIT_W-1:0] next_bit = last ? '0 : bit_idx + 1'b1;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= '0;
            bit_idx <= '0;
            bit_clk_o <= 1'b0;
            frame_sync_o <= 1'b0;
        end else if (!en_i) begin
            cnt <= '0;
            bit_idx <= '0;
            bit_clk_o <= 1'b0;
            frame_sync_o <= 1'b0;
        end else if (tick) begin
            cnt <= '0;
            bit_clk_o <= ~bit_clk_o;
            // frame sync moves on the falling bit clock edge
            if (bit_clk_o) begin
                bit_idx <= next_bit;
                frame_sync_o <= next_bit == '0;
            end
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule // arcm_clk_gen

/* design/arcm_pkg.sv */
// shared constants, types and code tables for the rate config monitor
package arcm_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned ADR_W = 8;

    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_CTL = 6'h13;
    localparam logic [5:0] IDX_CFG = 6'h14;
    localparam logic [5:0] IDX_STS = 6'h15;
    localparam logic [5:0] IDX_SRC = 6'h16;
    localparam logic [5:0] IDX_IRQ_STS = 6'h18;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h19;
    localparam logic [5:0] IDX_IRQ_EN = 6'h1A;

    // reset values
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h48;
    localparam logic [7:0] STS_RST = 8'hFF;
    localparam logic [7:0] SRC_RST = 8'h10;

    // field positions
    localparam int unsigned CTL_DIR_BIT = 7;
    localparam int unsigned CTL_AUTO_DIS_BIT = 6;
    localparam int unsigned CTL_FAMILY_BIT = 3;
    localparam logic [7:0] CTL_MASK = 8'hC8;
    localparam int unsigned CFG_RATE_LSB = 4;
    localparam int unsigned CFG_RATIO_LSB = 0;

    // interrupt layout
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RATE_BIT = 0;
    localparam int unsigned IRQ_RATIO_BIT = 1;
    localparam int unsigned IRQ_LOSS_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    localparam logic [3:0] CODE_INVALID = 4'hF;
    localparam int unsigned RATE_CODES = 9;
    localparam int unsigned RATIO_CODES = 13;

    // monitor widths and clock loss timeout: two of the slowest frames
    localparam int unsigned PER_W = 16;
    localparam int unsigned BIT_W = 12;
    localparam int unsigned RATE_MIN_HZ = 7350;
    localparam int unsigned LOSS_CYC_DEF = 2 * CLK_HZ / RATE_MIN_HZ;
    localparam int unsigned LOSS_CYC_MIN = 16;

    typedef enum logic [0:0] {
        MON_SEEK = 1'b0,
        MON_MEASURE = 1'b1
    } arcm_mon_state_t;

    // frame rate in Hz; 44.1k family is the 48k value times 147/160
    function automatic int unsigned rate_hz(input int unsigned code, input bit fam44);
        int unsigned base;
        case (code)
            0: base = 8000;
            1: base = 16000;
            2: base = 24000;
            3: base = 32000;
            4: base = 48000;
            5: base = 96000;
            6: base = 192000;
            7: base = 384000;
            default: base = 768000;
        endcase
        return fam44 ? base / 160 * 147 : base;
    endfunction

    function automatic int unsigned ratio_bits(input int unsigned code);
        int unsigned b;
        case (code)
            0: b = 16;
            1: b = 24;
            2: b = 32;
            3: b = 48;
            4: b = 64;
            5: b = 96;
            6: b = 128;
            7: b = 192;
            8: b = 256;
            9: b = 384;
            10: b = 512;
            11: b = 1024;
            default: b = 2048;
        endcase
        return b;
    endfunction

    // bit clock half period in clk cycles, at least one
    function automatic logic [PER_W-1:0] half_cycles(input logic [3:0] rc,
                                                     input logic fam, input logic [3:0] bc);
        int unsigned h;
        h = 1;
        for (int f = 0; f < 2; f++)
            for (int i = 0; i < RATE_CODES; i++)
                for (int j = 0; j < RATIO_CODES; j++)
                    if (fam == f[0] && rc == i[3:0] && bc == j[3:0])
                        h = CLK_HZ / (2 * rate_hz(i, f[0]) * ratio_bits(j));
        return (h == 0) ? 16'h0001 : h[PER_W-1:0];
    endfunction

    // frame period to rate code, either family, within 1/32
    function automatic logic [3:0] rate_code(input logic [PER_W-1:0] per);
        logic [3:0] c;
        int unsigned nom;
        c = CODE_INVALID;
        for (int f = 0; f < 2; f++)
            for (int i = 0; i < RATE_CODES; i++) begin
                nom = CLK_HZ / rate_hz(i, f[0]);
                if (per + nom / 32 >= nom && per <= nom + nom / 32)
                    c = i[3:0];
            end
        return c;
    endfunction

    function automatic logic [3:0] ratio_code(input logic [BIT_W-1:0] bits);
        logic [3:0] c;
        c = CODE_INVALID;
        for (int i = 0; i < RATIO_CODES; i++)
            if (bits == ratio_bits(i))
                c = i[3:0];
        return c;
    endfunction

endpackage

/* design/arcm_rate_monitor.sv */
// audio serial port rate configuration and bus clock monitor
// Overview of operation
// - rate code drives master frame timing only
// - rate codes 0-8 map family rate pairs
// - ratio code sets bit clocks per frame
// - config register resets to 0x48
// - detected rate in status upper nibble
// - invalid rate reads 15, never 9-14
// - detected ratio in status lower nibble
// - status register resets to 0xFF
// - master drives both clocks, slave receives
// - family bit: 48k (0), 44.1k (1)
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module arcm_rate_monitor #(
    parameter int unsigned LOSS_CYC = arcm_pkg::LOSS_CYC_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [arcm_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial link clocks
    input wire logic bit_clk_i,
    output logic bit_clk_o,
    output logic bit_clk_oe_o,
    input wire logic frame_sync_i,
    output logic frame_sync_o,
    output logic frame_sync_oe_o,
    // interrupt
    output logic irq_o
);
    import arcm_pkg::*;

    if (LOSS_CYC < LOSS_CYC_MIN || LOSS_CYC >= (1 << PER_W)) begin : g_bad_loss
        $error("LOSS_CYC out of range");
    end

    localparam logic [PER_W-1:0] PER_LIM = PER_W'(LOSS_CYC - 1);
    localparam logic [PER_W-1:0] PER_SAT = PER_W'(LOSS_CYC);
    localparam int unsigned NOM48 = CLK_HZ / 48000;
    localparam int unsigned NOM441 = CLK_HZ / 44100;

    logic [7:0] ctl;
    logic [7:0] cfg;
    logic [7:0] src;
    logic [3:0] det_rate;
    logic [3:0] det_ratio;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_en;
    logic [PER_W-1:0] half_q;
    logic [BIT_W-1:0] bits_q;
    logic [PER_W-1:0] per_cnt;
    logic [BIT_W-1:0] bit_cnt;
    logic [1:0] rise;
    logic gen_bit_clk;
    logic gen_frame_sync;
    arcm_mon_state_t state;

    // bus decode
    wire logic req = wb_cyc_i & wb_stb_i;
    wire logic [5:0] idx = wb_adr_i[7:2];
    wire logic aligned = wb_adr_i[1:0] == 2'b00;
    wire logic wr = req & wb_ack_o & wb_we_i & wb_sel_i[0] & aligned;
    wire logic wr_ctl = wr & (idx == IDX_CTL);
    wire logic wr_cfg = wr & (idx == IDX_CFG);
    wire logic wr_sts = wr & (idx == IDX_STS);
    wire logic wr_src = wr & (idx == IDX_SRC);
    wire logic wr_irq_clr = wr & (idx == IDX_IRQ_CLR);
    wire logic wr_irq_en = wr & (idx == IDX_IRQ_EN);
    wire logic [7:0] sts = {det_rate, det_ratio};

    // read selection, write-only and unmapped read zero
    wire logic [7:0] rdata =
        !aligned ? 8'h00 :
        (idx == IDX_CTL) ? ctl :
        (idx == IDX_CFG) ? cfg :
        (idx == IDX_STS) ? sts :
        (idx == IDX_SRC) ? src :
        (idx == IDX_IRQ_STS) ? {5'h00, irq_sts} :
        (idx == IDX_IRQ_EN) ? {5'h00, irq_en} :
        8'h00;

    // master setup
    wire logic master = ctl[CTL_DIR_BIT];
    wire logic fam44 = ctl[CTL_FAMILY_BIT];
    wire logic [3:0] prog_rate = cfg[CFG_RATE_LSB +: 4];
    wire logic [3:0] prog_ratio = cfg[CFG_RATIO_LSB +: 4];
    wire logic [PER_W-1:0] next_half = half_cycles(prog_rate, fam44, prog_ratio);
    wire logic [BIT_W-1:0] next_bits = BIT_W'(ratio_bits(prog_ratio));

    // monitor decode
    wire logic fs_rise = rise[1];
    wire logic bc_rise = rise[0];
    wire logic meas = state == MON_MEASURE;
    wire logic [3:0] next_rate = rate_code(per_cnt + 1'b1);
    wire logic [3:0] next_ratio = ratio_code(bit_cnt);
    wire logic loss = meas & ~fs_rise & (per_cnt == PER_LIM);
    wire logic [IRQ_W-1:0] ev = {loss,
                                 fs_rise & meas & (next_ratio != det_ratio),
                                 fs_rise & meas & (next_rate != det_rate)};
    wire logic [IRQ_W-1:0] clr = wr_irq_clr ? wb_dat_i[IRQ_W-1:0] : '0;
    wire logic [IRQ_W-1:0] next_irq_sts = (irq_sts & ~clr) | ev;

    // wishbone handshake: answer one cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o) begin
                wb_dat_o <= {24'h00_0000, rdata};
            end
        end
    end

    // software registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl <= CTL_RST;
            cfg <= CFG_RST;
            src <= SRC_RST;
            irq_en <= IRQ_RST;
        end else begin
            if (wr_ctl) ctl <= wb_dat_i[7:0] & CTL_MASK;
            if (wr_cfg) cfg <= wb_dat_i[7:0];
            if (wr_src) src <= wb_dat_i[7:0];
            if (wr_irq_en) irq_en <= wb_dat_i[IRQ_W-1:0];
        end
    end

    // pin drivers: generator runs only in master mode
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            half_q <= 16'h0001;
            bits_q <= 12'h100;
            bit_clk_oe_o <= 1'b0;
            frame_sync_oe_o <= 1'b0;
            bit_clk_o <= 1'b0;
            frame_sync_o <= 1'b0;
        end else begin
            half_q <= next_half;
            bits_q <= next_bits;
            bit_clk_oe_o <= master;
            frame_sync_oe_o <= master;
            bit_clk_o <= gen_bit_clk;
            frame_sync_o <= gen_frame_sync;
        end
    end

    arcm_clk_gen #(
        .CNT_W(PER_W),
        .BIT_W(BIT_W)
    ) u_gen (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .en_i(master),
        .half_i(half_q),
        .bits_i(bits_q),
        .bit_clk_o(gen_bit_clk),
        .frame_sync_o(gen_frame_sync)
    );

    arcm_sync_edge #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .din_i({frame_sync_i, bit_clk_i}),
        .rise_o(rise)
    );

    // frame measurement: clk cycles and bit clocks between frame syncs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= MON_SEEK;
            per_cnt <= '0;
            bit_cnt <= '0;
            det_rate <= STS_RST[7:4];
            det_ratio <= STS_RST[3:0];
        end else if (fs_rise) begin
            state <= MON_MEASURE;
            per_cnt <= '0;
            bit_cnt <= {{(BIT_W-1){1'b0}}, bc_rise};
            if (meas) begin
                det_rate <= next_rate;
                det_ratio <= next_ratio;
            end
        end else begin
            if (per_cnt != PER_SAT) per_cnt <= per_cnt + 1'b1;
            if (bc_rise && bit_cnt != '1) bit_cnt <= bit_cnt + 1'b1;
            // clocks stopped: report invalid until a new frame
            if (loss) begin
                state <= MON_SEEK;
                det_rate <= CODE_INVALID;
                det_ratio <= CODE_INVALID;
            end
        end
    end

    // sticky events, set wins over clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_sts <= IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            irq_sts <= next_irq_sts;
            irq_o <= |(next_irq_sts & irq_en);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_cfg_reset_value: assert property (
        $rose(reset_n_i) |-> cfg == 8'h48 ##1 prog_rate == 4'h4
    ) else $error("config register not 0x48 after reset");

    a_sts_reset_value: assert property (
        $rose(reset_n_i) |-> sts == 8'hFF
    ) else $error("status register not 0xFF after reset");

    a_rate_reserved: assert property (
        !(det_rate inside {[4'h9:4'hE]})
    ) else $error("reserved detected rate code reported");

    a_ratio_reserved: assert property (
        det_ratio <= 4'hC || det_ratio == 4'hF
    ) else $error("reserved detected ratio code reported");

    a_rate_48_match: assert property (
        fs_rise && meas && per_cnt == 16'(NOM48 - 1) |=> sts[7:4] == 4'h4
    ) else $error("48k frame not reported as code 4");

    a_rate_441_match: assert property (
        fs_rise && meas && per_cnt == 16'(NOM441 - 1) |=> det_rate == 4'h4
    ) else $error("44.1k frame not reported as code 4");

    a_ratio_256_match: assert property (
        fs_rise && meas && bit_cnt == 12'h100 |=> sts[3:0] == 4'h8
    ) else $error("256 bit frame not reported as code 8");

    a_first_frame_hold: assert property (
        fs_rise && !meas |=> $stable(det_rate) && $stable(det_ratio) ##1 meas
    ) else $error("status updated without a complete frame");

    a_loss_invalid: assert property (
        loss |=> det_rate == 4'hF && det_ratio == 4'hF && !meas
    ) else $error("clock loss did not mark status invalid");

    a_sts_write_ignored: assert property (
        wr_sts && !fs_rise && !loss |=> $stable(sts) && $stable(cfg)
    ) else $error("write to status register changed state");

    a_slave_pins_quiet: assert property (
        !master ##1 !master |=> !bit_clk_oe_o && !bit_clk_o && !frame_sync_o
    ) else $error("pins driven in slave mode");

    a_cfg_write_lands: assert property (
        wr_cfg |=> cfg == $past(wb_dat_i[7:0]) ##1 bits_q == next_bits
    ) else $error("config write not taken");

    a_ack_one_cycle: assert property (
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
    ) else $error("ack not a single cycle after request");

    a_loss_set_wins: assert property (
        ev[IRQ_LOSS_BIT] && clr[IRQ_LOSS_BIT] |=> irq_sts[IRQ_LOSS_BIT]
    ) else $error("clear overrode a simultaneous event");

    a_irq_level_out: assert property (
        (irq_sts & irq_en) != '0 && !wr_irq_clr && !wr_irq_en |=> irq_o
    ) else $error("enabled status bit without interrupt");

    a_ack_upper_zero: assert property (
        req && !wb_ack_o |=> wb_dat_o[31:8] == 24'h00_0000
    ) else $error("read data upper bytes not zero");

    a_ack_needs_req: assert property (
        !req |=> !wb_ack_o
    ) else $error("ack without a request");

    a_unmapped_zero: assert property (
        req && !wb_ack_o && !aligned |=> wb_dat_o == 32'h0000_0000
    ) else $error("misaligned read not zero");

    a_ctl_write_lands: assert property (
        wr_ctl |=> ctl == ($past(wb_dat_i[7:0]) & CTL_MASK)
    ) else $error("control write not taken");

    a_master_drives_pins: assert property (
        master |=> bit_clk_oe_o && frame_sync_oe_o
    ) else $error("master mode without pin enables");

    a_slave_gen_idle: assert property (
        !master |=> !gen_bit_clk && !gen_frame_sync
    ) else $error("generator running in slave mode");

    a_ratio_256_bits: assert property (
        prog_ratio == 4'h8 |-> next_bits == 12'h100
    ) else $error("ratio code 8 not 256 bits");

    a_ratio_64_bits: assert property (
        prog_ratio == 4'h4 |-> next_bits == 12'h040
    ) else $error("ratio code 4 not 64 bits");

    a_half_48_family: assert property (
        !fam44 && prog_rate == 4'h0 && prog_ratio == 4'h4 |-> next_half == 16'h0013
    ) else $error("8 kHz by 64 half period wrong");

    a_half_441_family: assert property (
        fam44 && prog_rate == 4'h0 && prog_ratio == 4'h4 |-> next_half == 16'h0015
    ) else $error("7.35 kHz by 64 half period wrong");

    a_status_frame_load: assert property (
        fs_rise && meas |=> det_rate == $past(next_rate) && det_ratio == $past(next_ratio)
    ) else $error("status not loaded at frame end");

    a_status_holds: assert property (
        !fs_rise && !loss |=> $stable(det_rate) && $stable(det_ratio)
    ) else $error("status changed inside a frame");

    a_ratio_change_event: assert property (
        fs_rise && meas && next_ratio != det_ratio |=> irq_sts[IRQ_RATIO_BIT]
    ) else $error("ratio change event not flagged");

    a_irq_masked_quiet: assert property (
        irq_en == '0 |=> !irq_o
    ) else $error("interrupt with all sources masked");

    a_fs_on_falling: assert property (
        $rose(gen_frame_sync) |-> $fell(gen_bit_clk)
    ) else $error("frame sync not on falling bit clock");

endmodule // arcm_rate_monitor

/* design/arcm_sync_edge.sv */
// two-flop synchroniser with rising edge detect per bit
`timescale 1ns/1ps
module arcm_sync_edge #(
    parameter int unsigned W = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // asynchronous levels in, edges out
    input wire logic [W-1:0] din_i,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;

    if (W < 1) begin : g_bad_w
        $error("W must be at least 1");
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
            rise_o <= '0;
        end else begin
            meta <= din_i;
            sync <= meta;
            prev <= sync;
            rise_o <= sync & ~prev;
        end
    end
endmodule // arcm_sync_edge

/* tb/arcm_host_model.sv */
// link partner model: drives bit clock and frame sync while the device is slave
`timescale 1ns/1ps
module arcm_host_model (
    // link clocks
    output logic bclk_o,
    output logic fs_o
);
    initial begin
        bclk_o = 1'b0;
        fs_o = 1'b0;
    end

    // n frames of bits each, one frame sync rise per period; clock stands still in the gap
    task automatic send(input int bits, input int period_ns, input int frames);
        #13;
        repeat (frames) begin
            for (int b = 0; b < bits; b++) begin
                fs_o = (b == 0);
                #200 bclk_o = 1'b1;
                #200 bclk_o = 1'b0;
            end
            fs_o = 1'b0;
            #(period_ns - bits * 400);
        end
    endtask
endmodule // arcm_host_model

/* tb/arcm_rate_monitor_tb.sv */
// self-checking bench for the rate config monitor
`timescale 1ns/1ps
module arcm_rate_monitor_tb;
    import arcm_pkg::*;
    localparam int unsigned LOSS = 3000;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic bit_clk_o, bit_clk_oe_o, frame_sync_o, frame_sync_oe_o, irq_o;
    logic host_bclk, host_fs;
    wire logic bclk_w = bit_clk_oe_o ? bit_clk_o : host_bclk;
    wire logic fs_w = frame_sync_oe_o ? frame_sync_o : host_fs;
    int errors = 0;
    int n_checks = 0;
    logic [31:0] v;

    arcm_rate_monitor #(.LOSS_CYC(LOSS)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .bit_clk_i(bclk_w), .bit_clk_o(bit_clk_o), .bit_clk_oe_o(bit_clk_oe_o),
        .frame_sync_i(fs_w), .frame_sync_o(frame_sync_o), .frame_sync_oe_o(frame_sync_oe_o),
        .irq_o(irq_o));
    arcm_host_model i_host (.bclk_o(host_bclk), .fs_o(host_fs));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                      input logic [3:0] sel, output logic [31:0] rdat);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= sel;
        // ack and read data taken at the rising edge that samples ack high
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 100);
        rdat = wb_dat_o;
        if (k >= 100) begin
            errors++;
            conclude();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] x;
        wb(1'b1, {idx, 2'b00}, d, 4'hF, x);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] x);
        wb(1'b0, {idx, 2'b00}, 8'h00, 4'hF, x);
    endtask

    // cycles and bit clock rises up to the next generated frame sync rise
    task automatic next_fs(output int cyc, output int rises);
        logic pf;
        logic pb;
        cyc = 0;
        rises = 0;
        pf = 1'b1;
        pb = bit_clk_o;
        while (cyc < 10000) begin
            @(negedge clk_i);
            cyc++;
            if (bit_clk_o && !pb) rises++;
            pb = bit_clk_o;
            if (frame_sync_o && !pf) return;
            pf = frame_sync_o;
        end
        errors++;
        conclude();
    endtask

    task automatic t_reset();
        rd(IDX_CFG, v);
        chk(v, 32'h48);
        rd(IDX_STS, v);
        chk(v, 32'hFF);
        rd(IDX_SRC, v);
        chk(v, 32'h10);
        chk({bit_clk_oe_o, frame_sync_oe_o}, 2'b00);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [31:0] x;
        wr(IDX_CFG, 8'h8C);
        rd(IDX_CFG, v);
        chk(v, 32'h8C);
        wb(1'b1, {IDX_CFG, 2'b00}, 8'h00, 4'hE, x);
        rd(IDX_CFG, v);
        chk(v, 32'h8C);
        wr(IDX_STS, 8'h00);
        rd(IDX_STS, v);
        chk(v, 32'hFF);
        wb(1'b0, 8'hFC, 8'h00, 4'hF, v);
        chk(v, 32'h0);
        wb(1'b0, 8'h51, 8'h00, 4'hF, v);
        chk(v, 32'h0);
        wr(IDX_CFG, 8'h48);
        $display("test registers done");
    endtask

    // slave mode frames from the host, then the detected status byte
    task automatic t_mon(input int bits, input int per_ns, input logic [7:0] exp);
        i_host.send(bits, per_ns, 3);
        rd(IDX_STS, v);
        chk(v, {24'h0, exp});
        $display("test monitor %0d bits done", bits);
    endtask

    task automatic t_irq_loss();
        wr(IDX_IRQ_EN, 8'h07);
        wr(IDX_IRQ_CLR, 8'h07);
        t_mon(256, 125000, 8'h08);
        rd(IDX_IRQ_STS, v);
        chk(v & 32'h3, 32'h3);
        chk(irq_o, 1'b1);
        wr(IDX_IRQ_CLR, 8'h07);
        rd(IDX_IRQ_STS, v);
        chk(v, 32'h0);
        chk(irq_o, 1'b0);
        wr(IDX_IRQ_EN, 8'h00);
        t_mon(16, 20800, 8'h40);
        chk(irq_o, 1'b0);
        t_mon(24, 22650, 8'h41);
        t_mon(20, 20800, 8'h4F);
        t_mon(16, 30000, 8'hF0);
        repeat (LOSS + 100) @(posedge clk_i);
        rd(IDX_STS, v);
        chk(v, 32'hFF);
        rd(IDX_IRQ_STS, v);
        chk(v & 32'h4, 32'h4);
        $display("test interrupt and loss done");
    endtask

    // master mode: ratio 64 at rate code 0, both families
    task automatic t_master(input logic [7:0] ctl, input int fs_hz);
        int c;
        int r;
        int half;
        half = 20_000_000 / (2 * fs_hz * 64);
        wr(IDX_CFG, 8'h04);
        wr(IDX_CTL, ctl);
        // enables follow the direction bit one edge later
        repeat (2) @(posedge clk_i);
        chk({bit_clk_oe_o, frame_sync_oe_o}, 2'b11);
        rd(IDX_CTL, v);
        chk(v, {24'h0, ctl});
        next_fs(c, r);
        next_fs(c, r);
        chk(c, 2 * half * 64);
        chk(r, 64);
        next_fs(c, r);
        rd(IDX_STS, v);
        chk(v, 32'h04);
        $display("test master %0d Hz done", fs_hz);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_regs();
        t_irq_loss();
        t_master(8'h80, 8000);
        t_master(8'h88, 7350);
        wr(IDX_CTL, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({bit_clk_oe_o, frame_sync_oe_o}, 2'b00);
        conclude();
    end
endmodule // arcm_rate_monitor_tb
